// ==== verilog/scmm_defs.svh ====
// offsets, field positions, reset values and timing counts of the mode manager
`ifndef SCMM_DEFS_SVH
`define SCMM_DEFS_SVH
`define SCMM_A_CTRL 8'h00
`define SCMM_A_CMD 8'h04
`define SCMM_A_STAT 8'h08
`define SCMM_A_RES 8'h0C
`define SCMM_A_PWD 8'h10
`define SCMM_A_CONN 8'h14
`define SCMM_F_DLY 0
`define SCMM_F_HOLD 1
`define SCMM_F_CNT 4
`define SCMM_F_RT 4
`define SCMM_F_PW 16
`define SCMM_RUN_BIT 6
`define SCMM_CTRL_RST 32'h0000_0000
`define SCMM_CLK_HZ 20000000
`define SCMM_MAX_S 20
`define SCMM_QUIET_S 5
`define SCMM_BLINK_MSEC 500
`define SCMM_CNT_W 29
`define SCMM_NSLV 16
`endif

// ==== verilog/scmm_pkg.sv ====
// types of the mode manager
`include "scmm_defs.svh"
package scmm_pkg;
  typedef enum logic [2:0] {
    SCMM_INIT = 3'h0,
    SCMM_WAIT_ID = 3'h1,
    SCMM_CONFIG = 3'h2,
    SCMM_IDLE = 3'h3,
    SCMM_RUN = 3'h4,
    SCMM_ABORT = 3'h5,
    SCMM_CRIT = 3'h6
  } scmm_mode_e;
  typedef enum logic [3:0] {
    OP_CFG = 4'h0,
    OP_LOCK = 4'h1,
    OP_UNLOCK = 4'h2,
    OP_RESET = 4'h3,
    OP_PWD = 4'h4,
    OP_MON = 4'h5,
    OP_MSG = 4'h6,
    OP_TO_RUN = 4'h7,
    OP_TO_IDLE = 4'h8
  } scmm_op_e;
  typedef logic [`SCMM_CNT_W-1:0] scmm_cnt_t;
endpackage : scmm_pkg

// ==== verilog/scmm_dly_if.sv ====
// execution delay handshake between mode manager and delay timer
`timescale 1ns/1ps
`default_nettype none
interface scmm_dly_if;
  logic run;
  logic enable;
  logic all_started;
  logic change;
  logic exec_go;
  modport ctl (output run, output enable, output all_started, output change, input exec_go);
  modport tmr (input run, input enable, input all_started, input change, output exec_go);
endinterface : scmm_dly_if
`default_nettype wire

// ==== verilog/scmm_exec_delay.sv ====
// program execution delay timer
`timescale 1ns/1ps
`default_nettype none
module scmm_exec_delay #(
  parameter scmm_pkg::scmm_cnt_t MAX_CYC = 29'h10,
  parameter scmm_pkg::scmm_cnt_t QUIET_CYC = 29'h8
) (
  input wire logic mclk,
  input wire logic srst,
  scmm_dly_if.tmr dly
);
  import scmm_pkg::*;
  scmm_cnt_t tot_q;
  scmm_cnt_t quiet_q;

  // ****************************************
  // timers started on run entry
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (srst || !dly.run)
    begin
      tot_q <= '0;
      quiet_q <= '0;
      dly.exec_go <= 1'b0;
    end
    else
    begin
      if (tot_q != MAX_CYC)
        tot_q <= tot_q + 1'b1;
      if (dly.change)
        quiet_q <= '0;
      else if (quiet_q != QUIET_CYC)
        quiet_q <= quiet_q + 1'b1;
      if (!dly.enable || dly.all_started || tot_q == MAX_CYC || quiet_q == QUIET_CYC)
        dly.exec_go <= 1'b1;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  AST_MAX_BOUND: assert property (@(posedge mclk) disable iff (srst)
    dly.run && tot_q == MAX_CYC |=> dly.exec_go || !dly.run)
    else $error("execution not released at the maximum delay");
  AST_QUIET_BOUND: assert property (@(posedge mclk) disable iff (srst)
    dly.run && quiet_q == QUIET_CYC && !dly.change |=> dly.exec_go || !dly.run)
    else $error("execution not released after quiet time");
  AST_HOLD_EXEC: assert property (@(posedge mclk) disable iff (srst)
    $rose(dly.exec_go) |-> !$past(dly.enable) || $past(dly.all_started)
      || $past(tot_q) == MAX_CYC || $past(quiet_q) == QUIET_CYC)
    else $error("execution released without cause");
  COV_TIMEOUT: cover property (@(posedge mclk) disable iff (srst)
    dly.enable && tot_q == MAX_CYC ##1 dly.exec_go);
endmodule : scmm_exec_delay
`default_nettype wire

// ==== verilog/scmm_top.sv ====
// safety controller operating mode manager with axi4-lite registers
// Function
// - indicator green run/idle, red error/abort, alternating while starting, dark unpowered
// - status word bit 6 set only in run
// - run executes program and i/o; other modes stop and hold safe
// - tool operations accepted per mode table
// - configuration download in run/idle needs unlocked configuration
// - reset in run/idle/abort depends on reset type and lock
// - password-guarded operations refused without matching password
// - run to idle data to master follows hold setting
// - normal startup enters idle; tool must command run
// - automatic execution, locked, last powered in run starts in run
// - power lost in idle never starts in run
// - idle and run change only on tool command
// - safety connections opened one after another per slave
// - safety data reads off until its connection is up
// - delay option holds program until safety communications start
// - execution delay ends at 20 seconds at most
// - execution starts after 5 seconds without connection change
// - switch change after configuration enters abort, outputs safe
// - unconfigured or bad configuration enters configuring
//
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "scmm_defs.svh"
module scmm_top #(
  parameter scmm_pkg::scmm_cnt_t EXEC_MAX_CYC = `SCMM_CNT_W'(`SCMM_MAX_S * `SCMM_CLK_HZ),
  parameter scmm_pkg::scmm_cnt_t QUIET_CYC = `SCMM_CNT_W'(`SCMM_QUIET_S * `SCMM_CLK_HZ),
  parameter scmm_pkg::scmm_cnt_t BLINK_CYC =
    `SCMM_CNT_W'(`SCMM_BLINK_MSEC * (`SCMM_CLK_HZ / 1000))
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic diag_ok,
  input wire logic diag_crit,
  input wire logic network_unique_identifier_ok,
  input wire logic switch_changed,
  input wire logic nv_cfg_ok,
  input wire logic nv_cfg_err,
  input wire logic nv_locked,
  input wire logic nv_auto,
  input wire logic nv_last_run,
  input wire logic [7:0] std_in,
  input wire logic [`SCMM_NSLV-1:0] conn_est,
  input wire logic [`SCMM_NSLV-1:0] safe_in,
  output scmm_pkg::scmm_mode_e op_mode_q,
  output logic module_mode_indicator_green_q,
  output logic module_mode_indicator_red_q,
  output logic prog_run_q,
  output logic safety_comm_q,
  output logic io_refresh_q,
  output logic std_comm_q,
  output logic msg_comm_q,
  output logic [7:0] master_in_q,
  output logic [`SCMM_NSLV-1:0] safe_data_q,
  output logic conn_open_q,
  output logic [3:0] conn_slot_q,
  output logic lock_q,
  output logic run_persist_q
);
  import scmm_pkg::*;
  localparam int PW = 9 + 8 + 2 * `SCMM_NSLV;

  function automatic logic mapped(input logic [7:0] a);
    mapped = a == `SCMM_A_CTRL || a == `SCMM_A_CMD || a == `SCMM_A_STAT
      || a == `SCMM_A_RES || a == `SCMM_A_PWD || a == `SCMM_A_CONN;
  endfunction : mapped

  function automatic logic [31:0] strb(input logic [31:0] o, input logic [31:0] n,
                                       input logic [3:0] s);
    for (int i = 0; i < 4; i++)
      strb[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
  endfunction : strb

  function automatic logic op_allowed(input scmm_mode_e m, input scmm_op_e op,
                                      input logic lk, input logic [1:0] rt);
    logic ri;
    logic live;
    ri = m == SCMM_RUN || m == SCMM_IDLE;
    live = m != SCMM_CRIT && m != SCMM_INIT && m != SCMM_WAIT_ID;
    case (op)
      OP_CFG: op_allowed = (ri && !lk) || m == SCMM_CONFIG;
      OP_LOCK, OP_UNLOCK: op_allowed = ri;
      OP_RESET: op_allowed = live && (rt == 2'h0 || !lk || m == SCMM_CONFIG);
      OP_PWD, OP_MON, OP_MSG: op_allowed = live;
      OP_TO_RUN: op_allowed = m == SCMM_IDLE;
      OP_TO_IDLE: op_allowed = m == SCMM_RUN;
      default: op_allowed = 1'b0;
    endcase
  endfunction : op_allowed

  logic [PW-1:0] s1_q;
  logic [PW-1:0] s2_q;
  logic diag_s, crit_s, uid_s, sw_s, cok_s, cerr_s, lk_s, auto_s, lrun_s;
  logic [7:0] std_s;
  logic [`SCMM_NSLV-1:0] est_s, safe_s, est_prev_q, opened_q;
  logic aw_got_q, w_got_q, wr_fire;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [31:0] ctrl_q, pwdnew_q, cmd_q, stat_w;
  logic cmd_v_q, cfg_ok_q, dflt_q, pwd_set_q, pw_need, pw_ok, cmd_acc, all_q, req_q;
  logic [15:0] pwd_q;
  logic [7:0] res_q;
  logic [4:0] conn_idx_q, nslv;
  scmm_op_e op;
  scmm_cnt_t blink_q;
  logic phase_q;
  scmm_dly_if dly ();

  // ****************************************
  // pin synchronisers
  // ****************************************
  always_ff @(posedge mclk)
  begin
    s1_q <= {diag_ok, diag_crit, network_unique_identifier_ok, switch_changed, nv_cfg_ok,
             nv_cfg_err, nv_locked, nv_auto, nv_last_run, std_in, conn_est, safe_in};
    s2_q <= s1_q;
  end
  assign {diag_s, crit_s, uid_s, sw_s, cok_s, cerr_s, lk_s, auto_s, lrun_s, std_s, est_s,
          safe_s} = s2_q;

  // ****************************************
  // axi4-lite write channel
  // ****************************************
  assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end
    else
    begin
      if (s_axi_awready && s_axi_awvalid)
      begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      else if (!aw_got_q && !s_axi_awready && !s_axi_bvalid)
        s_axi_awready <= 1'b1;
      if (s_axi_wready && s_axi_wvalid)
      begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      else if (!w_got_q && !s_axi_wready && !s_axi_bvalid)
        s_axi_wready <= 1'b1;
      if (wr_fire)
      begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(awaddr_q) ? 2'h0 : 2'h2;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************
  // register writes and command strobe
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      ctrl_q <= `SCMM_CTRL_RST;
      pwdnew_q <= 32'h0000_0000;
      cmd_q <= 32'h0000_0000;
      cmd_v_q <= 1'b0;
    end
    else
    begin
      cmd_v_q <= wr_fire && awaddr_q == `SCMM_A_CMD;
      if (wr_fire && awaddr_q == `SCMM_A_CTRL)
        ctrl_q <= strb(ctrl_q, wdata_q, wstrb_q);
      if (wr_fire && awaddr_q == `SCMM_A_PWD)
        pwdnew_q <= strb(pwdnew_q, wdata_q, wstrb_q);
      if (wr_fire && awaddr_q == `SCMM_A_CMD)
        cmd_q <= wdata_q;
    end
  end

  // ****************************************
  // axi4-lite read channel
  // ****************************************
  always_comb
  begin
    stat_w = 32'h0000_0000;
    stat_w[2:0] = op_mode_q;
    stat_w[3] = lock_q;
    stat_w[4] = cfg_ok_q;
    stat_w[5] = prog_run_q;
    stat_w[`SCMM_RUN_BIT] = op_mode_q == SCMM_RUN;
    stat_w[7] = all_q;
  end
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end
    else if (s_axi_arready && s_axi_arvalid)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= mapped(s_axi_araddr) ? 2'h0 : 2'h2;
      case (s_axi_araddr)
        `SCMM_A_CTRL: s_axi_rdata <= ctrl_q;
        `SCMM_A_CMD: s_axi_rdata <= cmd_q;
        `SCMM_A_STAT: s_axi_rdata <= stat_w;
        `SCMM_A_RES: s_axi_rdata <= {24'h00_0000, res_q};
        `SCMM_A_CONN: s_axi_rdata <= {16'h0000, est_s & opened_q};
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
    else if (!s_axi_rvalid)
      s_axi_arready <= 1'b1;
  end

  // ****************************************
  // command acceptance
  // ****************************************
  assign op = scmm_op_e'(cmd_q[3:0]);
  assign pw_need = op != OP_MON && op != OP_MSG;
  assign pw_ok = !pw_need || !pwd_set_q || cmd_q[`SCMM_F_PW +: 16] == pwd_q;
  assign cmd_acc = cmd_v_q && pw_ok
    && op_allowed(op_mode_q, op, lock_q, cmd_q[`SCMM_F_RT +: 2]);

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      pwd_q <= 16'h0000;
      pwd_set_q <= 1'b0;
      res_q <= 8'h00;
    end
    else if (cmd_v_q)
    begin
      res_q <= {cmd_q[3:0], 2'h0, !cmd_acc, cmd_acc};
      if (cmd_acc && op == OP_PWD)
      begin
        pwd_q <= pwdnew_q[15:0];
        pwd_set_q <= 1'b1;
      end
    end
  end

  // ****************************************
  // operating mode sequencer
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      op_mode_q <= SCMM_INIT;
      cfg_ok_q <= 1'b0;
      lock_q <= 1'b0;
      dflt_q <= 1'b0;
    end
    else if (crit_s)
      op_mode_q <= SCMM_CRIT;
    else if (sw_s && (op_mode_q == SCMM_IDLE || op_mode_q == SCMM_RUN))
      op_mode_q <= SCMM_ABORT;
    else if (cmd_acc)
    begin
      case (op)
        OP_CFG:
        begin
          cfg_ok_q <= 1'b1;
          dflt_q <= 1'b0;
          op_mode_q <= SCMM_IDLE;
        end
        OP_LOCK: lock_q <= 1'b1;
        OP_UNLOCK: lock_q <= 1'b0;
        OP_RESET:
        begin
          op_mode_q <= SCMM_INIT;
          if (cmd_q[`SCMM_F_RT +: 2] != 2'h0)
          begin
            dflt_q <= 1'b1;
            cfg_ok_q <= 1'b0;
            lock_q <= 1'b0;
          end
        end
        OP_TO_RUN: op_mode_q <= SCMM_RUN;
        OP_TO_IDLE: op_mode_q <= SCMM_IDLE;
        default: op_mode_q <= op_mode_q;
      endcase
    end
    else if ((op_mode_q == SCMM_INIT && diag_s) || (op_mode_q == SCMM_WAIT_ID && uid_s))
    begin
      cfg_ok_q <= cok_s && !cerr_s && !dflt_q;
      lock_q <= lk_s && !dflt_q;
      if (!uid_s)
        op_mode_q <= SCMM_WAIT_ID;
      else if (!cok_s || cerr_s || dflt_q)
        op_mode_q <= SCMM_CONFIG;
      else if (auto_s && lk_s && lrun_s)
        op_mode_q <= SCMM_RUN;
      else
        op_mode_q <= SCMM_IDLE;
    end
  end

  // ****************************************
  // functions gated by mode
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      prog_run_q <= 1'b0;
      safety_comm_q <= 1'b0;
      io_refresh_q <= 1'b0;
      std_comm_q <= 1'b0;
      msg_comm_q <= 1'b0;
      run_persist_q <= 1'b0;
      master_in_q <= 8'h00;
      safe_data_q <= '0;
    end
    else
    begin
      prog_run_q <= op_mode_q == SCMM_RUN && dly.exec_go;
      safety_comm_q <= op_mode_q == SCMM_RUN;
      io_refresh_q <= op_mode_q == SCMM_RUN;
      std_comm_q <= op_mode_q == SCMM_RUN || op_mode_q == SCMM_IDLE;
      msg_comm_q <= op_mode_q != SCMM_CRIT && op_mode_q != SCMM_INIT
        && op_mode_q != SCMM_WAIT_ID;
      run_persist_q <= op_mode_q == SCMM_RUN;
      safe_data_q <= (op_mode_q == SCMM_RUN) ? (safe_s & est_s & opened_q) : '0;
      if (op_mode_q == SCMM_RUN)
        master_in_q <= std_s;
      else if (!(op_mode_q == SCMM_IDLE && ctrl_q[`SCMM_F_HOLD]))
        master_in_q <= 8'h00;
    end
  end

  // ****************************************
  // safety connection sequencer
  // ****************************************
  assign nslv = (ctrl_q[`SCMM_F_CNT +: 5] > 5'h10) ? 5'h10 : ctrl_q[`SCMM_F_CNT +: 5];
  always_ff @(posedge mclk)
  begin
    if (srst || op_mode_q != SCMM_RUN)
    begin
      conn_idx_q <= 5'h00;
      conn_slot_q <= 4'h0;
      conn_open_q <= 1'b0;
      req_q <= 1'b0;
      opened_q <= '0;
      all_q <= 1'b0;
      est_prev_q <= '0;
    end
    else
    begin
      est_prev_q <= est_s;
      conn_open_q <= 1'b0;
      all_q <= conn_idx_q >= nslv;
      if (conn_idx_q < nslv && !req_q)
      begin
        conn_open_q <= 1'b1;
        conn_slot_q <= conn_idx_q[3:0];
        req_q <= 1'b1;
        opened_q[conn_idx_q[3:0]] <= 1'b1;
      end
      else if (req_q && est_s[conn_idx_q[3:0]])
      begin
        conn_idx_q <= conn_idx_q + 5'h01;
        req_q <= 1'b0;
      end
    end
  end

  assign dly.run = op_mode_q == SCMM_RUN;
  assign dly.enable = ctrl_q[`SCMM_F_DLY];
  assign dly.all_started = all_q;
  assign dly.change = est_s != est_prev_q;
  scmm_exec_delay #(.MAX_CYC(EXEC_MAX_CYC), .QUIET_CYC(QUIET_CYC)) u_delay (
    .mclk(mclk),
    .srst(srst),
    .dly(dly.tmr)
  );

  // ****************************************
  // mode indicator
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      blink_q <= '0;
      phase_q <= 1'b0;
      module_mode_indicator_green_q <= 1'b0;
      module_mode_indicator_red_q <= 1'b0;
    end
    else
    begin
      blink_q <= (blink_q >= BLINK_CYC - 1'b1) ? '0 : blink_q + 1'b1;
      if (blink_q >= BLINK_CYC - 1'b1)
        phase_q <= !phase_q;
      case (op_mode_q)
        SCMM_RUN, SCMM_IDLE:
        begin
          module_mode_indicator_green_q <= 1'b1;
          module_mode_indicator_red_q <= 1'b0;
        end
        SCMM_ABORT, SCMM_CRIT:
        begin
          module_mode_indicator_green_q <= 1'b0;
          module_mode_indicator_red_q <= 1'b1;
        end
        default:
        begin
          module_mode_indicator_green_q <= phase_q;
          module_mode_indicator_red_q <= !phase_q;
        end
      endcase
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);
  AST_RUN_FLAG: assert property (
    s_axi_arready && s_axi_arvalid && s_axi_araddr == `SCMM_A_STAT
    |=> s_axi_rdata[`SCMM_RUN_BIT] == ($past(op_mode_q) == SCMM_RUN))
    else $error("run flag disagrees with mode");
  AST_IND_RED: assert property (
    op_mode_q == SCMM_ABORT || op_mode_q == SCMM_CRIT
    |=> module_mode_indicator_red_q && !module_mode_indicator_green_q)
    else $error("indicator not red in abort or error");
  AST_PROG_OFF: assert property (
    op_mode_q != SCMM_RUN |=> !prog_run_q && !io_refresh_q)
    else $error("program running outside run");
  AST_RUN_BY_CMD: assert property (
    $past(op_mode_q) == SCMM_IDLE && op_mode_q == SCMM_RUN
    |-> $past(cmd_v_q) && $past(op) == OP_TO_RUN)
    else $error("run entered from idle without command");
  AST_REJECT_CHG: assert property (
    cmd_v_q && (op == OP_TO_RUN || op == OP_TO_IDLE)
    && !(op_mode_q == SCMM_IDLE || op_mode_q == SCMM_RUN)
    |=> res_q[1] && (op_mode_q == $past(op_mode_q) || op_mode_q == SCMM_CRIT))
    else $error("mode change accepted outside idle or run");
  AST_LOCKED_CFG: assert property (
    cmd_v_q && op == OP_CFG && lock_q
    && (op_mode_q == SCMM_IDLE || op_mode_q == SCMM_RUN) |=> res_q[1:0] == 2'h2)
    else $error("download accepted while locked");
  AST_PASSWORD: assert property (
    cmd_v_q && pw_need && pwd_set_q && cmd_q[`SCMM_F_PW +: 16] != pwd_q
    |=> res_q[1] && !res_q[0])
    else $error("operation accepted with wrong password");
  AST_CRIT_RESET: assert property (
    cmd_v_q && op == OP_RESET && op_mode_q == SCMM_CRIT |=> res_q[1] && op_mode_q == SCMM_CRIT)
    else $error("reset accepted in critical error");
  AST_SAFE_OFF: assert property (
    1'b1 |=> (safe_data_q & ~$past(est_s & opened_q)) == '0)
    else $error("safety data on without connection");
  COV_RUN: cover property ($past(op_mode_q) == SCMM_IDLE && op_mode_q == SCMM_RUN);
  COV_ABORT: cover property (op_mode_q == SCMM_ABORT);
  COV_EXEC: cover property (dly.enable && $rose(prog_run_q));
endmodule : scmm_top
`default_nettype wire

// ==== testbench/scmm_slave_model.sv ====
// safety slave model answering connection opens
`timescale 1ns/1ps
`default_nettype none
module scmm_slave_model (
  input wire logic mclk,
  input wire logic run,
  input wire logic conn_open_q,
  input wire logic [3:0] conn_slot_q,
  input var int lat,
  output logic [15:0] conn_est,
  output var int n_order
);
  // ****************
  // slave answers
  // ****************
  int cnt = 0;
  logic [3:0] slot = 4'h0;
  logic [3:0] nxt = 4'h0;
  initial conn_est = 16'h0;
  initial n_order = 0;
  always @(posedge mclk)
  begin
    if (!run)
    begin
      conn_est <= 16'h0;
      cnt <= 0;
      nxt <= 4'h0;
    end
    else if (conn_open_q)
    begin
      if (conn_slot_q !== nxt) n_order <= n_order + 1;
      nxt <= conn_slot_q + 4'h1;
      slot <= conn_slot_q;
      cnt <= lat;
    end
    else if (cnt == 1)
    begin
      conn_est[slot] <= 1'b1;
      cnt <= 0;
    end
    else if (cnt > 1) cnt <= cnt - 1;
  end
endmodule : scmm_slave_model
`default_nettype wire

// ==== testbench/safety_controller_mode_manager_tb.sv ====
// testbench of the mode manager
`timescale 1ns/1ps
`default_nettype none
`include "scmm_defs.svh"
module safety_controller_mode_manager_tb;
  import scmm_pkg::*;
  // ****************
  // stimulus and checks
  // ****************
  logic mclk = 0, srst = 1, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic awr, wr, bv, arr, rv, grn, red, prog, sc, io, copen, dok = 0, crit = 0, idok = 0;
  logic swc = 0, cok = 0, cerr = 0, lkd = 0, aut = 0, lrun = 0, stdc, msgc, lk, rp;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, sin = 8'h00, min;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [1:0] bresp, rresp, rsp;
  logic [15:0] est, sdata;
  logic [3:0] cslot;
  scmm_mode_e op;
  int n_errors = 0, checks = 0, lat = 4, n_order, n, i;
  int lat_t[3] = '{4, 100, 40};
  int lo_t[3] = '{6, 50, 199};
  int hi_t[3] = '{30, 56, 206};
  logic [31:0] ctl_t[3] = '{32'h21, 32'h21, 32'h101};
  scmm_top #(.EXEC_MAX_CYC(29'd200), .QUIET_CYC(29'd50), .BLINK_CYC(29'd4)) i_scmm_top (
    .mclk(mclk), .srst(srst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rready), .diag_ok(dok),
    .diag_crit(crit), .network_unique_identifier_ok(idok), .switch_changed(swc),
    .nv_cfg_ok(cok), .nv_cfg_err(cerr), .nv_locked(lkd), .nv_auto(aut),
    .nv_last_run(lrun), .std_in(sin), .conn_est(est), .safe_in(16'h5A5A), .op_mode_q(op),
    .module_mode_indicator_green_q(grn), .module_mode_indicator_red_q(red),
    .prog_run_q(prog), .safety_comm_q(sc), .io_refresh_q(io), .std_comm_q(stdc),
    .msg_comm_q(msgc), .master_in_q(min), .safe_data_q(sdata), .conn_open_q(copen),
    .conn_slot_q(cslot), .lock_q(lk), .run_persist_q(rp));
  scmm_slave_model i_scmm_slave_model (.mclk(mclk), .run(op == SCMM_RUN),
    .conn_open_q(copen), .conn_slot_q(cslot), .lat(lat), .conn_est(est), .n_order(n_order));
  always #25 mclk = ~mclk;
  task report_and_stop;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task axw(input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 50; k++)
    begin
      @(posedge mclk);
      if (awr && awv) awv <= 1'b0;
      if (wr && wv) wv <= 1'b0;
      if (bv)
      begin
        rsp = bresp;
        bready <= 1'b0;
        break;
      end
    end
    chk("b_wait", 32'h0, 32'(k == 50));
  endtask : axw
  task axr(input logic [7:0] a);
    int k;
    @(posedge mclk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 50; k++)
    begin
      @(posedge mclk);
      if (arr && arv) arv <= 1'b0;
      if (rv)
      begin
        rsp = rresp;
        rd = rdata;
        rready <= 1'b0;
        break;
      end
    end
    chk("r_wait", 32'h0, 32'(k == 50));
  endtask : axr
  task wmode(input scmm_mode_e m);
    for (n = 0; n < 100 && op !== m; n++) @(posedge mclk);
    @(posedge mclk);
    chk("op_mode", 32'(m), 32'(op));
  endtask : wmode
  task rst_to(input scmm_mode_e m);
    srst <= 1'b1;
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    wmode(m);
  endtask : rst_to
  task res(input logic [31:0] c, input logic [31:0] e);
    axw(`SCMM_A_CMD, c);
    axr(`SCMM_A_RES);
    chk("result", e, rd);
  endtask : res
  initial
  begin
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    chk("mode_at_reset", 32'(SCMM_INIT), 32'(op));
    dok <= 1'b1;
    idok <= 1'b1;
    cok <= 1'b1;
    sin <= 8'h5A;
    wmode(SCMM_IDLE);
    chk("indicator_idle", 32'h2, {grn, red});
    chk("comm_idle", 32'h3, {stdc, msgc});
    axr(`SCMM_A_STAT);
    chk("run_flag_idle", 32'h0, 32'(rd[`SCMM_RUN_BIT]));
    axr(8'h40);
    chk("unmapped", 32'h2, {rsp, rd[3:0]} >> 4);
    axw(8'h40, 32'h1);
    chk("unmapped_wr", 32'h2, 32'(rsp));
    res(4'h1, 32'h11);
    chk("lock_on", 32'h1, 32'(lk));
    res(4'h0, 32'h02);
    res(4'h2, 32'h21);
    axw(`SCMM_A_CTRL, 32'h2);
    chk("ctrl_wr", 32'h0, 32'(rsp));
    axr(`SCMM_A_CTRL);
    chk("ctrl_rd", 32'h2, rd);
    axw(`SCMM_A_CMD, 32'h7);
    wmode(SCMM_RUN);
    axr(`SCMM_A_STAT);
    chk("run_flag_run", 32'h1, 32'(rd[`SCMM_RUN_BIT]));
    chk("run_outputs", 32'hF, {prog, sc, io, rp});
    chk("master_run", 32'h5A, 32'(min));
    axw(`SCMM_A_CMD, 32'h8);
    wmode(SCMM_IDLE);
    sin <= 8'h3C;
    repeat (4) @(posedge mclk);
    chk("master_hold", 32'h5A, 32'(min));
    chk("idle_outputs", 32'h0, {prog, sc, io, rp});
    for (i = 0; i < 3; i++)
    begin
      lat <= lat_t[i];
      axw(`SCMM_A_CTRL, ctl_t[i]);
      axw(`SCMM_A_CMD, 32'h7);
      wmode(SCMM_RUN);
      for (n = 0; n < 400 && prog !== 1'b1; n++) @(posedge mclk);
      chk("release_time", 32'h1, 32'(n >= lo_t[i] && n <= hi_t[i]));
      if (i == 0) chk("safe_data", 32'h0002, 32'(sdata));
      axw(`SCMM_A_CMD, 32'h8);
      wmode(SCMM_IDLE);
    end
    chk("slot_order", 32'h0, 32'(n_order));
    chk("master_clear", 32'h0, 32'(min));
    swc <= 1'b1;
    wmode(SCMM_ABORT);
    chk("indicator_abort", 32'h1, {grn, red});
    chk("abort_outputs", 32'h1, {prog, sc, io, stdc, msgc});
    res(4'h7, 32'h72);
    crit <= 1'b1;
    wmode(SCMM_CRIT);
    chk("indicator_crit", 32'h1, {grn, red});
    res(4'h3, 32'h32);
    chk("crit_outputs", 32'h0, {prog, sc, io, stdc, msgc});
    crit <= 1'b0;
    swc <= 1'b0;
    aut <= 1'b1;
    lkd <= 1'b1;
    lrun <= 1'b1;
    rst_to(SCMM_RUN);
    chk("lock_restored", 32'h1, 32'(lk));
    res(32'h13, 32'h32);
    res(4'h3, 32'h31);
    wmode(SCMM_RUN);
    axw(`SCMM_A_CMD, 32'h8);
    wmode(SCMM_IDLE);
    lrun <= rp;
    rst_to(SCMM_IDLE);
    axw(`SCMM_A_PWD, 32'h1234);
    res(4'h4, 32'h41);
    res(4'h1, 32'h12);
    res(32'h1234_0001, 32'h11);
    cerr <= 1'b1;
    idok <= 1'b0;
    rst_to(SCMM_WAIT_ID);
    chk("indicator_wait", 32'h1, 32'(grn ^ red));
    idok <= 1'b1;
    wmode(SCMM_CONFIG);
    res(4'h0, 32'h01);
    wmode(SCMM_IDLE);
    report_and_stop();
  end
  initial
  begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    report_and_stop();
  end
endmodule : safety_controller_mode_manager_tb
`default_nettype wire
